// ---- emcy_pkg.sv ----
/*
 Constants, offsets and frame helpers for the emergency reporter.
 Assumes a single 50 MHz clock domain and an AXI4-Lite register bus.
*/
package emcy_pkg;
	// ----------------------------------------
	// Fault sources
	// ----------------------------------------
	localparam int unsigned NUM_SRC = 11;
	localparam int unsigned F_SELFTEST = 0;
	localparam int unsigned F_AUTOCAL = 1;
	localparam int unsigned F_XDCR = 2;
	localparam int unsigned F_SCALING = 3;
	localparam int unsigned F_PDO_OVR = 4;
	localparam int unsigned F_OVERLOAD = 5;
	localparam int unsigned F_LIMIT = 6;
	localparam int unsigned F_GROSS = 7;
	localparam int unsigned F_CALVAL = 8;
	localparam int unsigned F_LIMCFG = 9;
	localparam int unsigned F_NVM = 10;
	localparam int unsigned NUM_LIMIT = 4;

	// ----------------------------------------
	// Frame layout and codes
	// ----------------------------------------
	localparam logic [10:0] EMCY_ID_BASE = 11'h080;
	localparam logic [15:0] CODE_CLEAR = 16'h0000;
	localparam logic [15:0] CODE_SELFTEST = 16'h5010;
	localparam logic [15:0] CODE_AUTOCAL = 16'h5020;
	localparam logic [15:0] CODE_XDCR = 16'h5030;
	localparam logic [15:0] CODE_SCALING = 16'h6310;
	localparam logic [15:0] CODE_PDO_OVR = 16'h8110;
	localparam logic [15:0] CODE_OVERLOAD = 16'hF001;
	localparam logic [15:0] CODE_LIMIT = 16'hF011;
	localparam logic [15:0] CODE_DEVICE = 16'hFF00;
	localparam logic [7:0] EXT_NONE = 8'h00;
	localparam logic [7:0] EXT_GROSS = 8'h01;
	localparam logic [7:0] EXT_CALVAL = 8'h02;
	localparam logic [7:0] EXT_LIMCFG = 8'h03;
	localparam logic [7:0] EXT_NVM = 8'h04;
	localparam logic [7:0] STATUS_FAULT = 8'h01;
	localparam logic [7:0] STATUS_CLEAR = 8'h00;
	localparam logic [31:0] PAD_ZERO = 32'h0000_0000;
	localparam logic [31:0] ABORT_GENERAL = 32'h0800_0000;
	localparam logic [31:0] ABORT_NO_XFER = 32'h0800_0020;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam int unsigned AXI_AW = 8;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_NODE = 8'h04;
	localparam logic [7:0] REG_FAULT = 8'h08;
	localparam logic [7:0] REG_IRQ_STAT = 8'h0C;
	localparam logic [7:0] REG_IRQ_MASK = 8'h10;
	localparam logic [7:0] REG_ABORT = 8'h14;
	localparam int unsigned CTRL_USE_TDATA = 0;
	localparam int unsigned CTRL_LIMIT_EN_LSB = 4;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [6:0] NODE_RST = 7'h01;
	localparam int unsigned IRQ_W = 3;
	localparam int unsigned IRQ_RAISE = 0;
	localparam int unsigned IRQ_CLEAR = 1;
	localparam int unsigned IRQ_ABORT = 2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Payload bytes one..eight sit in bits [7:0]..[63:56]
	function automatic logic [63:0] pack_emcy(logic [15:0] code, logic [7:0] status, logic [7:0] ext);
		return {PAD_ZERO, ext, status, code[7:0], code[15:8]};
	endfunction : pack_emcy

	// Code part one and part two of one fault source
	function automatic logic [23:0] code_of(int unsigned idx);
		case (idx)
			F_SELFTEST: return {CODE_SELFTEST, EXT_NONE};
			F_AUTOCAL: return {CODE_AUTOCAL, EXT_NONE};
			F_XDCR: return {CODE_XDCR, EXT_NONE};
			F_SCALING: return {CODE_SCALING, EXT_NONE};
			F_PDO_OVR: return {CODE_PDO_OVR, EXT_NONE};
			F_OVERLOAD: return {CODE_OVERLOAD, EXT_NONE};
			F_LIMIT: return {CODE_LIMIT, EXT_NONE};
			F_GROSS: return {CODE_DEVICE, EXT_GROSS};
			F_CALVAL: return {CODE_DEVICE, EXT_CALVAL};
			F_LIMCFG: return {CODE_DEVICE, EXT_LIMCFG};
			F_NVM: return {CODE_DEVICE, EXT_NVM};
			default: return {CODE_CLEAR, EXT_NONE};
		endcase
	endfunction : code_of
endpackage : emcy_pkg

// ---- frame_if.sv ----
/*
 One CAN frame offered with valid/ready.
 Assumes the source holds id and data until ready.
*/
interface frame_if;
	logic valid;
	logic ready;
	logic [10:0] id;
	logic [63:0] data;
	modport src(output valid, output id, output data, input ready);
	modport snk(input valid, input id, input data, output ready);
endinterface : frame_if

// ---- emcy_source_tracker.sv ----
/*
 Edge tracker turning fault levels into emergency and clearing frames.
 Assumes fault levels come from logic on aclk.
*/
module emcy_source_tracker
	import emcy_pkg::*;
#(
	parameter int unsigned NSRC = emcy_pkg::NUM_SRC
)(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [NSRC-1:0] fault,
	input wire logic operational,
	input wire logic [6:0] node_addr,
	frame_if.src tx,
	output logic raise_sent,
	output logic clear_sent
);
	logic [NSRC-1:0] fault_q, fault_d, pend_r_q, pend_r_d, pend_c_q, pend_c_d, rep_q, rep_d;
	logic busy_q, busy_d, kind_clr_q, kind_clr_d;
	logic [10:0] id_q, id_d;
	logic [63:0] data_q, data_d;

	// ----------------------------------------
	// Pending flags and frame loader
	// ----------------------------------------
	// A new event on a source wins over the load that clears its flag
	always_comb
	begin
		logic [NSRC-1:0] rise, fall, lm;
		logic lclr, found;
		logic [23:0] cd;
		rise = fault & ~fault_q & {NSRC{operational}};
		fall = ~fault & fault_q;
		lm = '0;
		lclr = 1'b0;
		found = 1'b0;
		cd = '0;
		busy_d = busy_q;
		kind_clr_d = kind_clr_q;
		id_d = id_q;
		data_d = data_q;
		if (busy_q && tx.ready)
			busy_d = 1'b0;
		for (int unsigned i = 0; i < NSRC; i++)
		begin
			if (!busy_q && !found && (pend_r_q[i] || pend_c_q[i]))
			begin
				found = 1'b1;
				lm[i] = 1'b1;
				lclr = pend_c_q[i];
				cd = code_of(i);
			end
		end
		if (found)
		begin
			busy_d = 1'b1;
			kind_clr_d = lclr;
			id_d = EMCY_ID_BASE + {4'h0, node_addr};
			if (lclr)
				data_d = pack_emcy(CODE_CLEAR, STATUS_CLEAR, EXT_NONE);
			else
				data_d = pack_emcy(cd[23:8], STATUS_FAULT, cd[7:0]);
		end
		fault_d = fault;
		pend_r_d = (pend_r_q & ~(lm & {NSRC{!lclr}}) & ~fall) | rise;
		rep_d = (rep_q | (lm & {NSRC{!lclr}})) & ~(lm & {NSRC{lclr}});
		// Only a reported fault earns a clearing frame
		pend_c_d = (pend_c_q & ~(lm & {NSRC{lclr}})) | (fall & (rep_q | (lm & {NSRC{!lclr}})));
	end

	// Registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			fault_q <= '0;
			pend_r_q <= '0;
			pend_c_q <= '0;
			rep_q <= '0;
			busy_q <= 1'b0;
			kind_clr_q <= 1'b0;
			id_q <= '0;
			data_q <= '0;
		end
		else
		begin
			fault_q <= fault_d;
			pend_r_q <= pend_r_d;
			pend_c_q <= pend_c_d;
			rep_q <= rep_d;
			busy_q <= busy_d;
			kind_clr_q <= kind_clr_d;
			id_q <= id_d;
			data_q <= data_d;
		end
	end

	// Frame out and completion pulses
	assign tx.valid = busy_q;
	assign tx.id = id_q;
	assign tx.data = data_q;
	assign raise_sent = busy_q && tx.ready && !kind_clr_q;
	assign clear_sent = busy_q && tx.ready && kind_clr_q;
endmodule : emcy_source_tracker

// ---- frame_arbiter.sv ----
/*
 Output stage choosing emergency frames ahead of process-data frames.
 Assumes both sources hold their frame until taken.
*/
module frame_arbiter
	import emcy_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	frame_if.snk emcy,
	input wire logic pdo_valid,
	output logic pdo_ready,
	input wire logic [10:0] pdo_id,
	input wire logic [63:0] pdo_data,
	output logic can_tx_valid,
	input wire logic can_tx_ready,
	output logic [10:0] can_tx_id,
	output logic [63:0] can_tx_data,
	output logic can_tx_emcy
);
	logic v_q, v_d, e_q, e_d;
	logic [10:0] id_q, id_d;
	logic [63:0] dat_q, dat_d;
	logic free;

	// ----------------------------------------
	// One-deep output register
	// ----------------------------------------
	// Emergency frames always take the free slot first
	assign free = !v_q || can_tx_ready;
	assign emcy.ready = free;
	assign pdo_ready = free && !emcy.valid;

	always_comb
	begin
		v_d = v_q && !can_tx_ready;
		e_d = e_q;
		id_d = id_q;
		dat_d = dat_q;
		if (free && emcy.valid)
		begin
			v_d = 1'b1;
			e_d = 1'b1;
			id_d = emcy.id;
			dat_d = emcy.data;
		end
		else if (free && pdo_valid)
		begin
			v_d = 1'b1;
			e_d = 1'b0;
			id_d = pdo_id;
			dat_d = pdo_data;
		end
	end

	// Registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			v_q <= 1'b0;
			e_q <= 1'b0;
			id_q <= '0;
			dat_q <= '0;
		end
		else
		begin
			v_q <= v_d;
			e_q <= e_d;
			id_q <= id_d;
			dat_q <= dat_d;
		end
	end

	assign can_tx_valid = v_q;
	assign can_tx_emcy = e_q;
	assign can_tx_id = id_q;
	assign can_tx_data = dat_q;
endmodule : frame_arbiter

// ---- emcy_reporter.sv ----
/*
 Emergency frame reporter with AXI4-Lite registers, interrupt and abort codes.
 Assumes fault, limit and NMT levels come from logic on aclk.
*/
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
// What this block does
// - Emergency only when operational, on new fault
// - Clearing frame zero code, byte four, status
// - Separate enable for each of four switches
// - One frame when first enabled switch trips
// - Clear only when all enabled switches inactive
// - Identifier is 128 plus module address
// - Code, status, code part two, zero pad
// - Codes 5010, 5020, 5030 for hardware faults
// - Codes 6310 scaling, 8110 transmit overrun
// - Codes F001 overload, F011 limit switch
// - FF00 with byte four 01 to 04
// - Transducer data check only when enabled
// - Abort codes 08000000 and 08000020
module emcy_reporter
	import emcy_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [emcy_pkg::AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [emcy_pkg::AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic nmt_operational,
	input wire logic selftest_err,
	input wire logic autocal_err,
	input wire logic xdcr_conn_err,
	input wire logic xdcr_data_missing,
	input wire logic scaling_err,
	input wire logic pdo_overrun,
	input wire logic input_overload,
	input wire logic [emcy_pkg::NUM_LIMIT-1:0] limit_sw,
	input wire logic gross_overshoot,
	input wire logic calval_err,
	input wire logic limcfg_err,
	input wire logic nvm_err,
	input wire logic sdo_abort_req,
	input wire logic sdo_abort_no_xfer,
	output logic [31:0] sdo_abort_code,
	output logic sdo_abort_valid,
	input wire logic pdo_valid,
	output logic pdo_ready,
	input wire logic [10:0] pdo_id,
	input wire logic [63:0] pdo_data,
	output logic can_tx_valid,
	input wire logic can_tx_ready,
	output logic [10:0] can_tx_id,
	output logic [63:0] can_tx_data,
	output logic can_tx_emcy,
	output logic irq
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	frame_if em();
	logic [NUM_SRC-1:0] src;
	logic limit_any, raise_sent, clear_sent;
	logic [7:0] ctrl_q, ctrl_d;
	logic [6:0] node_q, node_d;
	logic [IRQ_W-1:0] ist_q, ist_d, imask_q, imask_d;
	logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
	logic [AXI_AW-1:0] awa_q, awa_d;
	logic [7:0] wd_q, wd_d;
	logic wb_q, wb_d;
	logic [1:0] br_q, br_d, rr_q, rr_d;
	logic [31:0] rd_q, rd_d, ab_q, ab_d;
	logic abv_q, abv_d;

	// ----------------------------------------
	// Fault source assembly
	// ----------------------------------------
	// Disabled switches are masked before the OR, so they never open or hold the event
	assign limit_any = |(limit_sw & ctrl_q[CTRL_LIMIT_EN_LSB +: NUM_LIMIT]);
	assign src[F_SELFTEST] = selftest_err;
	assign src[F_AUTOCAL] = autocal_err;
	assign src[F_XDCR] = xdcr_conn_err | (xdcr_data_missing & ctrl_q[CTRL_USE_TDATA]);
	assign src[F_SCALING] = scaling_err;
	assign src[F_PDO_OVR] = pdo_overrun;
	assign src[F_OVERLOAD] = input_overload;
	assign src[F_LIMIT] = limit_any;
	assign src[F_GROSS] = gross_overshoot;
	assign src[F_CALVAL] = calval_err;
	assign src[F_LIMCFG] = limcfg_err;
	assign src[F_NVM] = nvm_err;

	// Edge tracker and output arbitration
	emcy_source_tracker #(.NSRC(NUM_SRC)) u_trk (
		.aclk(aclk),
		.aresetn(aresetn),
		.fault(src),
		.operational(nmt_operational),
		.node_addr(node_q),
		.tx(em.src),
		.raise_sent(raise_sent),
		.clear_sent(clear_sent)
	);

	frame_arbiter u_arb (
		.aclk(aclk),
		.aresetn(aresetn),
		.emcy(em.snk),
		.pdo_valid(pdo_valid),
		.pdo_ready(pdo_ready),
		.pdo_id(pdo_id),
		.pdo_data(pdo_data),
		.can_tx_valid(can_tx_valid),
		.can_tx_ready(can_tx_ready),
		.can_tx_id(can_tx_id),
		.can_tx_data(can_tx_data),
		.can_tx_emcy(can_tx_emcy)
	);

	// ----------------------------------------
	// AXI4-Lite slave and registers
	// ----------------------------------------
	// All writable fields sit in byte lane 0, so only wstrb[0] matters
	always_comb
	begin
		logic [IRQ_W-1:0] rclr;
		rclr = '0;
		aw_d = aw_q;
		w_d = w_q;
		awa_d = awa_q;
		wd_d = wd_q;
		wb_d = wb_q;
		bv_d = bv_q && !s_axi_bready;
		br_d = br_q;
		rv_d = rv_q && !s_axi_rready;
		rr_d = rr_q;
		rd_d = rd_q;
		ctrl_d = ctrl_q;
		node_d = node_q;
		imask_d = imask_q;
		if (s_axi_awvalid && !aw_q)
		begin
			aw_d = 1'b1;
			awa_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_q)
		begin
			w_d = 1'b1;
			wd_d = s_axi_wdata[7:0];
			wb_d = s_axi_wstrb[0];
		end
		if (aw_q && w_q && !bv_q)
		begin
			aw_d = 1'b0;
			w_d = 1'b0;
			bv_d = 1'b1;
			br_d = RESP_OKAY;
			unique case ({awa_q[AXI_AW-1:2], 2'b00})
				REG_CTRL: if (wb_q) ctrl_d = wd_q;
				REG_NODE: if (wb_q) node_d = wd_q[6:0];
				REG_IRQ_MASK: if (wb_q) imask_d = wd_q[IRQ_W-1:0];
				REG_FAULT, REG_IRQ_STAT, REG_ABORT: br_d = RESP_OKAY;
				default: br_d = RESP_SLVERR;
			endcase
		end
		if (s_axi_arvalid && !rv_q)
		begin
			rv_d = 1'b1;
			rr_d = RESP_OKAY;
			rd_d = '0;
			unique case ({s_axi_araddr[AXI_AW-1:2], 2'b00})
				REG_CTRL: rd_d[7:0] = ctrl_q;
				REG_NODE: rd_d[6:0] = node_q;
				REG_FAULT: rd_d[NUM_SRC-1:0] = src;
				REG_IRQ_STAT:
				begin
					rd_d[IRQ_W-1:0] = ist_q;
					rclr = ist_q;
				end
				REG_IRQ_MASK: rd_d[IRQ_W-1:0] = imask_q;
				REG_ABORT: rd_d = ab_q;
				default: rr_d = RESP_SLVERR;
			endcase
		end
		// A new event wins over the read that clears it
		ist_d = (ist_q & ~rclr) | {sdo_abort_req, clear_sent, raise_sent};
	end

	// ----------------------------------------
	// Abort code
	// ----------------------------------------
	always_comb
	begin
		abv_d = sdo_abort_req;
		ab_d = ab_q;
		if (sdo_abort_req)
			ab_d = sdo_abort_no_xfer ? ABORT_NO_XFER : ABORT_GENERAL;
	end

	// Registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			awa_q <= '0;
			wd_q <= '0;
			wb_q <= 1'b0;
			bv_q <= 1'b0;
			br_q <= RESP_OKAY;
			rv_q <= 1'b0;
			rr_q <= RESP_OKAY;
			rd_q <= '0;
			ctrl_q <= CTRL_RST;
			node_q <= NODE_RST;
			imask_q <= '0;
			ist_q <= '0;
			ab_q <= '0;
			abv_q <= 1'b0;
		end
		else
		begin
			aw_q <= aw_d;
			w_q <= w_d;
			awa_q <= awa_d;
			wd_q <= wd_d;
			wb_q <= wb_d;
			bv_q <= bv_d;
			br_q <= br_d;
			rv_q <= rv_d;
			rr_q <= rr_d;
			rd_q <= rd_d;
			ctrl_q <= ctrl_d;
			node_q <= node_d;
			imask_q <= imask_d;
			ist_q <= ist_d;
			ab_q <= ab_d;
			abv_q <= abv_d;
		end
	end

	// Bus outputs and interrupt
	assign s_axi_awready = !aw_q;
	assign s_axi_wready = !w_q;
	assign s_axi_bvalid = bv_q;
	assign s_axi_bresp = br_q;
	assign s_axi_arready = !rv_q;
	assign s_axi_rvalid = rv_q;
	assign s_axi_rresp = rr_q;
	assign s_axi_rdata = rd_q;
	assign sdo_abort_code = ab_q;
	assign sdo_abort_valid = abv_q;
	assign irq = |(ist_q & imask_q);

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_emcy_id;
		@(posedge aclk) disable iff (!aresetn)
		can_tx_valid && can_tx_emcy |-> can_tx_id == EMCY_ID_BASE + {4'h0, node_q};
	endproperty
	a_emcy_id: assert property (p_emcy_id) else $error("emergency id wrong");

	property p_pad_zero;
		@(posedge aclk) disable iff (!aresetn)
		can_tx_valid && can_tx_emcy |-> can_tx_data[63:32] == PAD_ZERO;
	endproperty
	a_pad_zero: assert property (p_pad_zero) else $error("pad bytes not zero");

	property p_clear_frame;
		@(posedge aclk) disable iff (!aresetn)
		can_tx_valid && can_tx_emcy && can_tx_data[15:0] == CODE_CLEAR |-> can_tx_data[31:16] == 16'h0000;
	endproperty
	a_clear_frame: assert property (p_clear_frame) else $error("clear frame not zero");

	property p_pdo_yield;
		@(posedge aclk) disable iff (!aresetn)
		em.valid && (!can_tx_valid || can_tx_ready) |=> can_tx_valid && can_tx_emcy;
	endproperty
	a_pdo_yield: assert property (p_pdo_yield) else $error("pdo taken before emergency");

	property p_abort_code;
		@(posedge aclk) disable iff (!aresetn)
		sdo_abort_req |=> sdo_abort_valid && sdo_abort_code == ($past(sdo_abort_no_xfer) ? ABORT_NO_XFER : ABORT_GENERAL);
	endproperty
	a_abort_code: assert property (p_abort_code) else $error("abort code wrong");

	property p_limit_gate;
		@(posedge aclk) disable iff (!aresetn)
		(limit_sw & ctrl_q[CTRL_LIMIT_EN_LSB +: NUM_LIMIT]) == 4'h0 |-> !src[F_LIMIT];
	endproperty
	a_limit_gate: assert property (p_limit_gate) else $error("disabled switch reported");

	property p_tdata_gate;
		@(posedge aclk) disable iff (!aresetn)
		!ctrl_q[CTRL_USE_TDATA] && !xdcr_conn_err |-> !src[F_XDCR];
	endproperty
	a_tdata_gate: assert property (p_tdata_gate) else $error("transducer data check not gated");

	property p_no_quiet_send;
		@(posedge aclk) disable iff (!aresetn)
		$rose(src[F_LIMIT]) && !nmt_operational
		|=> !u_trk.pend_r_q[F_LIMIT];
	endproperty
	a_no_quiet_send: assert property (p_no_quiet_send) else $error("frame while not operational");

	property p_limit_once;
		@(posedge aclk) disable iff (!aresetn)
		src[F_LIMIT] && $past(src[F_LIMIT]) && $changed(limit_sw) |=> $stable(u_trk.pend_r_q[F_LIMIT]) || !u_trk.pend_r_q[F_LIMIT];
	endproperty
	a_limit_once: assert property (p_limit_once) else $error("extra limit frame queued");

	c_raise: cover property (@(posedge aclk) disable iff (!aresetn) raise_sent);
	c_clear: cover property (@(posedge aclk) disable iff (!aresetn) clear_sent);
	c_pdo: cover property (@(posedge aclk) disable iff (!aresetn) can_tx_valid && can_tx_ready && !can_tx_emcy);
	c_abort: cover property (@(posedge aclk) disable iff (!aresetn) sdo_abort_valid);
endmodule : emcy_reporter

// ---- can_sink_model.sv ----
/*
 Far-side frame sink standing in for the node that takes frames off the bus.
 Assumes frames are offered with valid/ready on aclk; only ready is driven.
*/
module can_sink_model
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic hold,
	input wire logic slow,
	output logic frame_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] cnt_q;
	logic [1:0] cnt_d;

	// ----------------------------------------
	// Acceptance pacing
	// ----------------------------------------
	// Free-running phase count for the slow mode
	always_comb
		cnt_d = cnt_q + 2'h1;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			cnt_q <= 2'h0;
		else
			cnt_q <= cnt_d;
	end
	// Slow takes one frame in four cycles, so the sender must hold its frame
	assign frame_ready = aresetn && !hold && (!slow || cnt_q == 2'h3);
endmodule : can_sink_model

// ---- emcy_reporter_tb_top.sv ----
/*
 Self-checking bench for the emergency reporter: register bus, frames, aborts.
 Assumes the package constants and the frame sink model are compiled first.
*/
module emcy_reporter_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import emcy_pkg::*;
	logic aclk = 0, aresetn = 0;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, acode;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid, tv, tr, te, irq, av;
	logic [1:0] bresp, rresp;
	logic op = 0, xdm = 0, abrq = 0, nx = 0, hold = 0, slow = 0, pvalid = 0, pready;
	logic [10:0] flt = 0, pid = 0, tid;
	logic [3:0] lim = 0;
	logic [63:0] pdata = 0, tdata;
	logic [75:0] fq[$];
	int bad_count = 0, n_tests = 0, cyc = 0;
	localparam logic [10:0] ID = EMCY_ID_BASE + 11'h005;
	localparam logic [75:0] CLR = {1'b1, ID, 64'h0};
	logic [23:0] ctab [11] = '{{CODE_SELFTEST, EXT_NONE}, {CODE_AUTOCAL, EXT_NONE}, {CODE_XDCR, EXT_NONE},
		{CODE_SCALING, EXT_NONE}, {CODE_PDO_OVR, EXT_NONE}, {CODE_OVERLOAD, EXT_NONE}, {CODE_LIMIT, EXT_NONE},
		{CODE_DEVICE, EXT_GROSS}, {CODE_DEVICE, EXT_CALVAL}, {CODE_DEVICE, EXT_LIMCFG}, {CODE_DEVICE, EXT_NVM}};

	always #10 aclk = ~aclk;

	emcy_reporter u_emcy_reporter (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .nmt_operational(op), .selftest_err(flt[F_SELFTEST]),
		.autocal_err(flt[F_AUTOCAL]), .xdcr_conn_err(flt[F_XDCR]), .xdcr_data_missing(xdm),
		.scaling_err(flt[F_SCALING]), .pdo_overrun(flt[F_PDO_OVR]), .input_overload(flt[F_OVERLOAD]),
		.limit_sw(lim), .gross_overshoot(flt[F_GROSS]), .calval_err(flt[F_CALVAL]),
		.limcfg_err(flt[F_LIMCFG]), .nvm_err(flt[F_NVM]), .sdo_abort_req(abrq), .sdo_abort_no_xfer(nx),
		.sdo_abort_code(acode), .sdo_abort_valid(av), .pdo_valid(pvalid), .pdo_ready(pready),
		.pdo_id(pid), .pdo_data(pdata), .can_tx_valid(tv), .can_tx_ready(tr), .can_tx_id(tid),
		.can_tx_data(tdata), .can_tx_emcy(te), .irq(irq));

	can_sink_model u_can_sink_model (.aclk(aclk), .aresetn(aresetn), .hold(hold), .slow(slow), .frame_ready(tr));

	// ----------------------------------------
	// Frame capture and hang guard
	// ----------------------------------------
	// Every frame the sink takes, in order
	always @(posedge aclk)
	begin
		if (tv === 1'b1 && tr === 1'b1)
			fq.push_back({te, tid, tdata});
		cyc++;
		if (cyc == 20000)
		begin
			bad_count++;
			complete_run();
		end
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic complete_run();
		if (bad_count == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : complete_run

	task automatic chk(input logic [75:0] got, input logic [75:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[ERR] %0t seen %h wanted %h", $time, got, exp);
		end
	endtask : chk

	// Handshakes judged at the falling edge, where ready has settled
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, bv;
		logic [1:0] r;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		do
		begin
			@(negedge aclk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			bv = bvalid;
			r = bresp;
			@(posedge aclk);
			if (ta)
				awvalid <= 0;
			if (tw)
				wvalid <= 0;
		end
		while (!bv);
		bready <= 0;
		chk(r, RESP_OKAY);
	endtask : axw

	// Data is compared only when an OKAY answer is expected
	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic ta, rv;
		logic [31:0] d;
		logic [1:0] r;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do
		begin
			@(negedge aclk);
			ta = arvalid && arready;
			rv = rvalid;
			d = rdata;
			r = rresp;
			@(posedge aclk);
			if (ta)
				arvalid <= 0;
		end
		while (!rv);
		rready <= 0;
		chk({r, (er === RESP_OKAY) ? d : ed}, {er, ed});
	endtask : rd

	task automatic pdo(input logic [10:0] i, input logic [63:0] d);
		@(posedge aclk);
		pid <= i;
		pdata <= d;
		pvalid <= 1;
		do
			@(negedge aclk);
		while (!pready);
		@(posedge aclk);
		pvalid <= 0;
	endtask : pdo

	task automatic expf(input logic [75:0] exp);
		int n;
		n = 0;
		while (fq.size() == 0 && n < 80)
		begin
			@(posedge aclk);
			n++;
		end
		chk((fq.size() != 0) ? fq.pop_front() : {76{1'bx}}, exp);
	endtask : expf

	// Silence check: no frame may leave in a generous window
	task automatic expn();
		repeat (20) @(posedge aclk);
		chk(fq.size(), 0);
	endtask : expn

	function automatic logic [75:0] fr(input logic [23:0] c);
		return {1'b1, ID, PAD_ZERO, c[7:0], STATUS_FAULT, c[15:8], c[23:16]};
	endfunction : fr

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		repeat (10) @(posedge aclk);
		aresetn <= 1;
		rd(REG_CTRL, 32'h0, RESP_OKAY);
		rd(REG_NODE, {25'h0, NODE_RST}, RESP_OKAY);
		rd(8'h20, 32'h0, RESP_SLVERR);
		axw(REG_NODE, 32'h5);
		axw(REG_IRQ_MASK, 32'h3);
		axw(REG_CTRL, 32'h30);
		op <= 1;
		for (int i = 0; i < 11; i++)
		begin
			if (i != F_LIMIT)
			begin
				slow <= i[0];
				flt[i] <= 1;
				expf(fr(ctab[i]));
				expn();
				flt[i] <= 0;
				expf(CLR);
			end
		end
		chk(irq, 1);
		rd(REG_IRQ_STAT, 32'h3, RESP_OKAY);
		rd(REG_IRQ_STAT, 32'h0, RESP_OKAY);
		chk(irq, 0);
		lim <= 4'h1;
		expf(fr({CODE_LIMIT, EXT_NONE}));
		lim <= 4'h3;
		expn();
		lim <= 4'h7;
		expn();
		lim <= 4'h6;
		expn();
		lim <= 4'h4;
		expf(CLR);
		lim <= 4'h0;
		xdm <= 1;
		expn();
		axw(REG_CTRL, 32'h31);
		expf(fr(ctab[F_XDCR]));
		xdm <= 0;
		expf(CLR);
		op <= 0;
		flt[F_NVM] <= 1;
		lim <= 4'h1;
		expn();
		op <= 1;
		expn();
		flt[F_NVM] <= 0;
		lim <= 4'h0;
		expn();
		// Stalled output: a waiting emergency must overtake queued process data
		hold <= 1;
		fork
			begin
				pdo(11'h181, 64'h1111);
				pdo(11'h182, 64'h2222);
			end
		join_none
		repeat (4) @(posedge aclk);
		flt[F_SCALING] <= 1;
		repeat (10) @(posedge aclk);
		hold <= 0;
		expf({1'b0, 11'h181, 64'h1111});
		expf(fr(ctab[F_SCALING]));
		expf({1'b0, 11'h182, 64'h2222});
		flt[F_SCALING] <= 0;
		expf(CLR);
		rd(REG_IRQ_STAT, 32'h3, RESP_OKAY);
		for (int k = 0; k < 2; k++)
		begin
			abrq <= 1;
			nx <= k[0];
			@(posedge aclk);
			abrq <= 0;
			@(negedge aclk);
			chk(av, 1);
			chk(acode, k[0] ? ABORT_NO_XFER : ABORT_GENERAL);
			@(posedge aclk);
		end
		chk(irq, 0);
		axw(REG_IRQ_MASK, 32'h7);
		chk(irq, 1);
		rd(REG_ABORT, ABORT_NO_XFER, RESP_OKAY);
		rd(REG_IRQ_STAT, 32'h4, RESP_OKAY);
		chk(irq, 0);
		complete_run();
	end
endmodule : emcy_reporter_tb_top
